//--- design/isc_slave.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - seven-bit mode compares shift 7:1 with address
// - ten-bit first byte: header 11110, address 9:8
// - first ten-bit write match pulses, clears match
// - ten-bit mismatch or read before full match clears match, idles
// - second byte matches address 7:0, sets match
// - idle until start, sample on SCL rise
// - address match acks, pulse at ninth fall
// - read match acks, holds SCL until reload
// - transmit pulses at ninth fall regardless ack
// - write match receives, loads buffer, acks
// - buffer full: no ack, pulse, no load
// - overflow set, buffer empty: load, no ack
// - transmit stretches regardless stretch-enable
// - transmit ack with empty register stretches
// - software may set release bit anytime
// - receive stretch when buffer full at ninth
// - ten-bit addressing stretches as seven-bit after address
// - software clear waits for SCL fall, low
// - SCL held until release bit set or module disabled
// - stretch disabled ignores release bit clears
// - accepted byte goes to buffer with pulse
// - transmit register write sets full flag
module isc_slave (
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // i2c pins, open drain: oe high pulls the wire low
  input wire logic sclIn,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOe,
  // slave event pulse
  output logic slaveIrq,
  // axi4-lite write address
  input wire logic [isc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [isc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  isc_pkg::isc_ctrl_t linkControl;
  isc_pkg::isc_phase_t phase;
  isc_pkg::isc_phase_t pendingPhase;
  logic [9:0] slaveAddress;
  logic [7:0] rxShift;
  logic [7:0] rxBuffer;
  logic [7:0] txRegister;
  logic [7:0] txShift;
  logic [3:0] bitCnt;
  logic [isc_pkg::ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic rxFull, rxOverflow, txFull, clockRelease, tenBitMatch;
  logic fullyAddressed, readDir, ackSeen, txPending, sclArmed;
  logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal, input logic [31:0] newVal,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeLanes

  function automatic logic isMapped(input logic [isc_pkg::ADDR_W-1:0] a);
    return (a == isc_pkg::OFS_CTRL) || (a == isc_pkg::OFS_STAT) || (a == isc_pkg::OFS_RXBUF) ||
           (a == isc_pkg::OFS_TXREG) || (a == isc_pkg::OFS_SADDR);
  endfunction : isMapped

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      {sclMeta, sclSync, sclPrev} <= 3'h7;
      {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
    end else if (clockEnable) begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  logic sclRise, sclFall, startCond, stopCond, ninthFall, byteDone;
  assign sclRise = sclSync & ~sclPrev;
  assign sclFall = ~sclSync & sclPrev;
  assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;
  assign ninthFall = sclFall && (bitCnt == isc_pkg::ACK_BIT) && (phase != isc_pkg::PH_IDLE);
  assign byteDone = sclFall && (bitCnt == isc_pkg::BYTE_BITS) && (phase != isc_pkg::PH_IDLE) &&
                    (phase != isc_pkg::PH_TX);

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic wrEn, rdEn;
  logic [31:0] ctrlWord, statWord, wrWord;
  assign wrEn = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rdEn = s_axi_arvalid & s_axi_arready;

  always_comb begin
    ctrlWord = isc_pkg::WORD_ZERO;
    ctrlWord[isc_pkg::CTRL_EN_BIT] = linkControl.moduleEnable;
    ctrlWord[isc_pkg::CTRL_REL_BIT] = clockRelease;
    ctrlWord[isc_pkg::CTRL_A10_BIT] = linkControl.tenBitAddrMode;
    ctrlWord[isc_pkg::CTRL_STRETCH_ENABLE_BIT] = linkControl.stretchEnable;
    statWord = isc_pkg::WORD_ZERO;
    statWord[isc_pkg::STAT_TXF_BIT] = txFull;
    statWord[isc_pkg::STAT_RXF_BIT] = rxFull;
    statWord[isc_pkg::STAT_DIR_BIT] = readDir;
    statWord[isc_pkg::STAT_OV_BIT] = rxOverflow;
    statWord[isc_pkg::STAT_TENM_BIT] = tenBitMatch;
    case (awAddr)
      isc_pkg::OFS_CTRL: wrWord = mergeLanes(ctrlWord, wData, wStrb);
      isc_pkg::OFS_STAT: wrWord = mergeLanes(statWord, wData, wStrb);
      isc_pkg::OFS_TXREG: wrWord = mergeLanes({24'h000000, txRegister}, wData, wStrb);
      isc_pkg::OFS_SADDR: wrWord = mergeLanes({22'h0, slaveAddress}, wData, wStrb);
      default: wrWord = isc_pkg::WORD_ZERO;
    endcase
  end

  logic wrCtrl, wrStat, wrTx;
  assign wrCtrl = wrEn && (awAddr == isc_pkg::OFS_CTRL);
  assign wrStat = wrEn && (awAddr == isc_pkg::OFS_STAT);
  assign wrTx = wrEn && (awAddr == isc_pkg::OFS_TXREG) && wStrb[0];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= isc_pkg::RESP_OKAY;
      awAddr <= '0;
      wData <= isc_pkg::WORD_ZERO;
      wStrb <= 4'h0;
    end else if (clockEnable) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr) ? isc_pkg::RESP_OKAY : isc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= isc_pkg::WORD_ZERO;
      s_axi_rresp <= isc_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      if (rdEn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= isMapped(s_axi_araddr) ? isc_pkg::RESP_OKAY : isc_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          isc_pkg::OFS_CTRL: s_axi_rdata <= ctrlWord;
          isc_pkg::OFS_STAT: s_axi_rdata <= statWord;
          isc_pkg::OFS_RXBUF: s_axi_rdata <= {24'h000000, rxBuffer};
          isc_pkg::OFS_TXREG: s_axi_rdata <= {24'h000000, txRegister};
          isc_pkg::OFS_SADDR: s_axi_rdata <= {22'h0, slaveAddress};
          default: s_axi_rdata <= isc_pkg::WORD_ZERO;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // byte decisions
  // ----------------------------------------------------------------
  logic match7, matchHigh, matchLow, ackDecide;
  logic rxLoad, rxOvfEvent, txLoad, txStretch, rxStretch;
  assign match7 = rxShift[7:1] == slaveAddress[6:0];
  assign matchHigh = (rxShift[7:3] == isc_pkg::TEN_BIT_HEADER) && (rxShift[2:1] == slaveAddress[9:8]);
  assign matchLow = rxShift == slaveAddress[7:0];

  always_comb begin
    case (phase)
      isc_pkg::PH_ADDR: begin
        if (!linkControl.tenBitAddrMode) begin
          ackDecide = match7;
        end else begin
          // a read header only answers after a complete ten-bit match
          ackDecide = matchHigh && (!rxShift[0] || fullyAddressed);
        end
      end
      isc_pkg::PH_ADDR_LOW: ackDecide = matchLow;
      isc_pkg::PH_RX: ackDecide = !rxFull && !rxOverflow;
      default: ackDecide = 1'b0;
    endcase
  end

  assign rxLoad = byteDone && (phase == isc_pkg::PH_RX) && !rxFull;
  assign rxOvfEvent = byteDone && (phase == isc_pkg::PH_RX) && rxFull;
  assign txLoad = (phase == isc_pkg::PH_TX) &&
                  ((ninthFall && ackSeen && txFull) || (txPending && clockRelease));
  assign txStretch = ninthFall && (phase == isc_pkg::PH_TX) && ackSeen && !txFull;
  assign rxStretch = ninthFall && (phase == isc_pkg::PH_RX) && linkControl.stretchEnable &&
                     (rxFull || rxLoad);

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      phase <= isc_pkg::PH_IDLE;
      pendingPhase <= isc_pkg::PH_IDLE;
      bitCnt <= 4'h0;
      rxShift <= isc_pkg::BYTE_RST;
      txShift <= isc_pkg::BYTE_RST;
      sdaOe <= 1'b0;
      slaveIrq <= 1'b0;
      ackSeen <= 1'b0;
      txPending <= 1'b0;
      tenBitMatch <= 1'b0;
      fullyAddressed <= 1'b0;
      readDir <= 1'b0;
    end else if (clockEnable) begin
      slaveIrq <= ninthFall;
      if (!linkControl.moduleEnable || stopCond) begin
        phase <= isc_pkg::PH_IDLE;
        fullyAddressed <= 1'b0;
        txPending <= 1'b0;
        sdaOe <= 1'b0;
      end else if (startCond) begin
        phase <= isc_pkg::PH_ADDR;
        bitCnt <= 4'h0;
        txPending <= 1'b0;
        sdaOe <= 1'b0;
      end else if (phase != isc_pkg::PH_IDLE) begin
        if (sclRise && bitCnt < isc_pkg::ACK_BIT) begin
          bitCnt <= bitCnt + isc_pkg::CNT_STEP;
          if (bitCnt < isc_pkg::BYTE_BITS) begin
            rxShift <= {rxShift[6:0], sdaSync};
          end else begin
            ackSeen <= ~sdaSync;
          end
        end
        if (byteDone) begin
          sdaOe <= ackDecide;
          if (phase == isc_pkg::PH_ADDR) begin
            readDir <= rxShift[0];
            if (!ackDecide) begin
              phase <= isc_pkg::PH_IDLE;
              if (linkControl.tenBitAddrMode) begin
                tenBitMatch <= 1'b0;
              end
            end else if (!linkControl.tenBitAddrMode) begin
              pendingPhase <= rxShift[0] ? isc_pkg::PH_TX : isc_pkg::PH_RX;
            end else if (!rxShift[0]) begin
              pendingPhase <= isc_pkg::PH_ADDR_LOW;
              tenBitMatch <= 1'b0;
              fullyAddressed <= 1'b0;
            end else begin
              pendingPhase <= isc_pkg::PH_TX;
            end
          end else if (phase == isc_pkg::PH_ADDR_LOW) begin
            tenBitMatch <= matchLow;
            fullyAddressed <= matchLow;
            if (!matchLow) begin
              phase <= isc_pkg::PH_IDLE;
            end else begin
              pendingPhase <= isc_pkg::PH_RX;
            end
          end
        end else if (sclFall && phase == isc_pkg::PH_TX && bitCnt < isc_pkg::BYTE_BITS &&
                     bitCnt != 4'h0) begin
          sdaOe <= ~txShift[7];
          txShift <= {txShift[6:0], 1'b1};
        end else if (sclFall && phase == isc_pkg::PH_TX && bitCnt == isc_pkg::BYTE_BITS) begin
          sdaOe <= 1'b0;
        end
        if (ninthFall) begin
          bitCnt <= 4'h0;
          sdaOe <= 1'b0;
          if (phase == isc_pkg::PH_ADDR || phase == isc_pkg::PH_ADDR_LOW) begin
            phase <= pendingPhase;
            txPending <= pendingPhase == isc_pkg::PH_TX;
          end else if (phase == isc_pkg::PH_TX && !ackSeen) begin
            phase <= isc_pkg::PH_IDLE;
          end else if (txStretch) begin
            txPending <= 1'b1;
          end
        end
        if (txLoad) begin
          // first bit goes out while SCL is low; the rest follow each fall
          sdaOe <= ~txRegister[7];
          txShift <= {txRegister[6:0], 1'b1};
          txPending <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // software-visible flags and registers
  // ----------------------------------------------------------------
  logic addrReadAck;
  assign addrReadAck = ninthFall && (phase == isc_pkg::PH_ADDR) && (pendingPhase == isc_pkg::PH_TX);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      linkControl <= isc_pkg::CTRL_RST;
      slaveAddress <= isc_pkg::SADDR_RST;
      txRegister <= isc_pkg::BYTE_RST;
      rxBuffer <= isc_pkg::BYTE_RST;
      rxFull <= 1'b0;
      rxOverflow <= 1'b0;
      txFull <= 1'b0;
      clockRelease <= 1'b1;
    end else if (clockEnable) begin
      if (wrCtrl) begin
        linkControl.moduleEnable <= wrWord[isc_pkg::CTRL_EN_BIT];
        linkControl.tenBitAddrMode <= wrWord[isc_pkg::CTRL_A10_BIT];
        linkControl.stretchEnable <= wrWord[isc_pkg::CTRL_STRETCH_ENABLE_BIT];
      end
      if (wrEn && awAddr == isc_pkg::OFS_SADDR) begin
        slaveAddress <= wrWord[9:0];
      end
      if (wrTx) begin
        txRegister <= wrWord[7:0];
      end
      if (rxLoad) begin
        rxBuffer <= rxShift;
      end
      // set wins over the read that clears it
      if (rxLoad) begin
        rxFull <= 1'b1;
      end else if (rdEn && s_axi_araddr == isc_pkg::OFS_RXBUF) begin
        rxFull <= 1'b0;
      end
      if (rxOvfEvent) begin
        rxOverflow <= 1'b1;
      end else if (wrStat) begin
        rxOverflow <= rxOverflow & wrWord[isc_pkg::STAT_OV_BIT];
      end
      if (wrTx) begin
        txFull <= 1'b1;
      end else if (txLoad) begin
        txFull <= 1'b0;
      end
      // a software set beats a same-cycle hardware stretch
      if (wrCtrl && wrWord[isc_pkg::CTRL_REL_BIT]) begin
        clockRelease <= 1'b1;
      end else if (txStretch || rxStretch || addrReadAck) begin
        clockRelease <= 1'b0;
      end else if (wrCtrl && linkControl.stretchEnable) begin
        clockRelease <= wrWord[isc_pkg::CTRL_REL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // SCL hold: only pull low after a seen fall with SCL still low,
  // so a late software clear never shortens a high phase
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sclArmed <= 1'b0;
      sclOe <= 1'b0;
    end else if (clockEnable) begin
      if (sclFall) begin
        sclArmed <= 1'b1;
      end else if (clockRelease) begin
        sclArmed <= 1'b0;
      end
      // hold through the cycle that drives the first bit, so SDA never moves while SCL is high
      if (!linkControl.moduleEnable || (clockRelease && !txLoad)) begin
        sclOe <= 1'b0;
      end else if (sclArmed && !sclSync) begin
        sclOe <= 1'b1;
      end
    end
  end

endmodule : isc_slave

`default_nettype wire

//--- dv/isc_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module isc_i2c_master (
  // bus wires
  input wire logic sclWire,
  input wire logic sdaWire,
  // pull-low requests
  output logic sclLow,
  output logic sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // one bit: data moves only while the clock is low, the slave may stretch
  task automatic bitOut(input logic b, output logic s);
    #16 sdaLow = !b;
    #16 sclLow = 1'b0;
    wait (sclWire);
    #16 s = sdaWire;
    #16 sclLow = 1'b1;
  endtask : bitOut
  task automatic start();
    #16 sdaLow = 1'b0;
    #16 sclLow = 1'b0;
    wait (sclWire);
    #32 sdaLow = 1'b1;
    #32 sclLow = 1'b1;
  endtask : start
  task automatic stop();
    #16 sdaLow = 1'b1;
    #16 sclLow = 1'b0;
    wait (sclWire);
    #32 sdaLow = 1'b0;
  endtask : stop
  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i], s);
    end
    bitOut(1'b1, s);
    ack = !s;
    #40;
  endtask : byteOut
  task automatic byteIn(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(1'b1, s);
      d[i] = s;
    end
    bitOut(!ack, s);
    #40;
  endtask : byteIn
endmodule : isc_i2c_master
`default_nettype wire

//--- dv/isc_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module isc_slave_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link pins
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic slaveIrq,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // cycles since the last accepted write word; only software lets go of a held clock
  logic [3:0] sinceWr;
  always_ff @(posedge clock) begin
    if (!reset_n || (s_axi_wvalid && s_axi_wready)) begin
      sinceWr <= 4'h0;
    end else if (sinceWr != 4'hF) begin
      sinceWr <= sinceWr + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wrAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (wrTaken |=> wrAnswer)
    else $error("write answer not two cycles after take");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_irq_pulse: assert property (slaveIrq |-> !sclIn ##1 !slaveIrq)
    else $error("event pulse wrong");
  chk_sda_on_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line moved while clock high");
  chk_hold_on_low: assert property ($rose(sclOe) |-> !$past(sclIn))
    else $error("clock held without a low");
  chk_release_by_sw: assert property ($fell(sclOe) |-> sinceWr < 4'h8)
    else $error("clock released without software");
endmodule : isc_slave_asserts
`default_nettype wire

//--- dv/isc_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module isc_slave_test;
  localparam logic [31:0] EN = 32'h1 << isc_pkg::CTRL_EN_BIT;
  localparam logic [31:0] REL = 32'h1 << isc_pkg::CTRL_REL_BIT;
  localparam logic [31:0] A10 = 32'h1 << isc_pkg::CTRL_A10_BIT;
  localparam logic [31:0] STR = 32'h1 << isc_pkg::CTRL_STRETCH_ENABLE_BIT;
  localparam logic [31:0] TXF = 32'h1 << isc_pkg::STAT_TXF_BIT;
  localparam logic [31:0] RXF = 32'h1 << isc_pkg::STAT_RXF_BIT;
  localparam logic [31:0] OVF = 32'h1 << isc_pkg::STAT_OV_BIT;
  localparam logic [31:0] TENM = 32'h1 << isc_pkg::STAT_TENM_BIT;
  logic clock, reset_n, sclOe, sdaOe, slaveIrq, sclLow, sdaLow;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [1:0] bResp, rResp;
  int n_mismatch = 0;
  int checks = 0;
  int irqCnt = 0;
  int base;
  // both lines are pulled up: low whenever any party pulls
  wire logic sclWire = !(sclOe || sclLow);
  wire logic sdaWire = !(sdaOe || sdaLow);
  isc_slave isc_slave_i (.clock(clock), .reset_n(reset_n), .clockEnable(1'b1), .sclIn(sclWire),
    .sclOe(sclOe), .sdaIn(sdaWire), .sdaOe(sdaOe), .slaveIrq(slaveIrq), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  isc_i2c_master m (.sclWire(sclWire), .sdaWire(sdaWire), .sclLow(sclLow), .sdaLow(sdaLow));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (slaveIrq === 1'b1) irqCnt <= irqCnt + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clock);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clock);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask : rd
  task automatic expReg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d & mask, exp);
  endtask : expReg
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    expReg(isc_pkg::OFS_CTRL, 32'hFFFF_FFFF, REL);
    expReg(isc_pkg::OFS_STAT, 32'hFFFF_FFFF, 32'h0);
    expReg(isc_pkg::OFS_SADDR, 32'hFFFF_FFFF, 32'h0);
    rd(8'h14, d, r);
    check(32'(r), 32'(isc_pkg::RESP_SLVERR));
  endtask : t_reset
  task automatic t_seven_write();
    logic ack;
    wr(isc_pkg::OFS_SADDR, 32'h2A);
    wr(isc_pkg::OFS_CTRL, EN | REL);
    m.start();
    m.byteOut(8'h56, ack);
    check(32'(ack), 32'h0);
    m.stop();
    base = irqCnt;
    m.start();
    m.byteOut(8'h54, ack);
    check(32'(ack), 32'h1);
    m.byteOut(8'h5A, ack);
    check(32'(ack), 32'h1);
    expReg(isc_pkg::OFS_STAT, RXF, RXF);
    m.byteOut(8'h33, ack);
    check(32'(ack), 32'h0);
    expReg(isc_pkg::OFS_RXBUF, 32'hFF, 32'h5A);
    expReg(isc_pkg::OFS_STAT, OVF | RXF, OVF);
    check(32'(sclOe), 32'h0);
    m.byteOut(8'h77, ack);
    check(32'(ack), 32'h0);
    m.stop();
    expReg(isc_pkg::OFS_RXBUF, 32'hFF, 32'h77);
    check(irqCnt - base, 32'h4);
    wr(isc_pkg::OFS_STAT, 32'h0);
    expReg(isc_pkg::OFS_STAT, OVF, 32'h0);
  endtask : t_seven_write
  task automatic t_seven_read();
    logic ack;
    logic [7:0] d;
    wr(isc_pkg::OFS_CTRL, EN);
    expReg(isc_pkg::OFS_CTRL, REL, REL);
    base = irqCnt;
    m.start();
    m.byteOut(8'h55, ack);
    check(32'(ack), 32'h1);
    expReg(isc_pkg::OFS_STAT, TXF, 32'h0);
    check(32'(sclOe), 32'h1);
    wr(isc_pkg::OFS_TXREG, 32'hC3);
    expReg(isc_pkg::OFS_STAT, TXF, TXF);
    wr(isc_pkg::OFS_CTRL, EN | REL);
    m.byteIn(d, 1'b1);
    check(32'(d), 32'hC3);
    expReg(isc_pkg::OFS_STAT, TXF, 32'h0);
    check(32'(sclOe), 32'h1);
    wr(isc_pkg::OFS_TXREG, 32'h3C);
    wr(isc_pkg::OFS_CTRL, EN | REL);
    m.byteIn(d, 1'b0);
    check(32'(d), 32'h3C);
    m.stop();
    check(irqCnt - base, 32'h3);
  endtask : t_seven_read
  task automatic t_ten();
    logic ack;
    logic [7:0] d;
    wr(isc_pkg::OFS_SADDR, 32'h2A5);
    wr(isc_pkg::OFS_CTRL, EN | A10 | STR);
    wr(isc_pkg::OFS_CTRL, EN | A10 | STR);
    expReg(isc_pkg::OFS_CTRL, REL, 32'h0);
    check(32'(sclOe), 32'h0);
    wr(isc_pkg::OFS_CTRL, EN | A10 | STR | REL);
    base = irqCnt;
    m.start();
    m.byteOut(8'hF5, ack);
    check(32'(ack), 32'h0);
    m.stop();
    m.start();
    m.byteOut(8'hF4, ack);
    check(32'(ack), 32'h1);
    expReg(isc_pkg::OFS_STAT, TENM, 32'h0);
    m.byteOut(8'hA6, ack);
    check(32'(ack), 32'h0);
    m.stop();
    m.start();
    m.byteOut(8'hF4, ack);
    m.byteOut(8'hA5, ack);
    check(32'(ack), 32'h1);
    expReg(isc_pkg::OFS_STAT, TENM, TENM);
    m.byteOut(8'h11, ack);
    check(32'(ack), 32'h1);
    expReg(isc_pkg::OFS_STAT, RXF, RXF);
    check(32'(sclOe), 32'h1);
    expReg(isc_pkg::OFS_RXBUF, 32'hFF, 32'h11);
    wr(isc_pkg::OFS_CTRL, EN | A10 | STR | REL);
    m.start();
    m.byteOut(8'hF5, ack);
    check(32'(ack), 32'h1);
    wr(isc_pkg::OFS_TXREG, 32'h96);
    check(32'(sclOe), 32'h1);
    wr(isc_pkg::OFS_CTRL, EN | A10 | STR | REL);
    m.byteIn(d, 1'b0);
    check(32'(d), 32'h96);
    m.stop();
    check(irqCnt - base, 32'h6);
  endtask : t_ten
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0000_0000;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_seven_write();
    t_seven_read();
    t_ten();
    print_verdict();
  end
endmodule : isc_slave_test
bind isc_slave isc_slave_asserts isc_slave_asserts_i (.clock(clock), .reset_n(reset_n), .sclIn(sclIn),
  .sclOe(sclOe), .sdaOe(sdaOe), .slaveIrq(slaveIrq), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- pkg/isc_pkg.sv
package isc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_RXBUF = 8'h08;
  localparam logic [7:0] OFS_TXREG = 8'h0C;
  localparam logic [7:0] OFS_SADDR = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_REL_BIT = 12;
  localparam int CTRL_A10_BIT = 10;
  localparam int CTRL_STRETCH_ENABLE_BIT = 6;
  localparam int STAT_TXF_BIT = 0;
  localparam int STAT_RXF_BIT = 1;
  localparam int STAT_DIR_BIT = 2;
  localparam int STAT_OV_BIT = 6;
  localparam int STAT_TENM_BIT = 8;

  // ----------------------------------------------------------------
  // protocol constants and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] TEN_BIT_HEADER = 5'h1E;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [9:0] SADDR_RST = 10'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ADDR_LOW,
    PH_RX,
    PH_TX
  } isc_phase_t;

  typedef struct packed {
    logic moduleEnable;
    logic tenBitAddrMode;
    logic stretchEnable;
  } isc_ctrl_t;

  localparam isc_ctrl_t CTRL_RST = isc_ctrl_t'(3'h0);

endpackage : isc_pkg
